//--- hdl/fpx_class.sv
// Classifies a packed double into the result class code
`timescale 1ns/1ns
`default_nettype none
`include "fpx_map.svh"

module fpx_class (
	input  wire logic [63:0] val,
	output logic      [4:0]  cls
);
	logic        sgn;
	logic [10:0] ex;
	logic        fz;

	always_comb begin
		sgn = val[63];
		ex  = val[62:52];
		fz  = (val[51:0] == `FPX_FRAC_ZERO);
		if (ex == `FPX_EXP_ALL1)
			cls = sgn ? `FPX_CLS_NINF : `FPX_CLS_PINF;
		else if (ex == 11'h000)
			cls = fz ? (sgn ? `FPX_CLS_NZERO : `FPX_CLS_PZERO) : (sgn ? `FPX_CLS_NDEN : `FPX_CLS_PDEN);
		else
			cls = sgn ? `FPX_CLS_NNORM : `FPX_CLS_PNORM;
	end

endmodule

`default_nettype wire

//--- hdl/fpx_map.svh
// Register offsets, field positions, reset values and numeric constants of the exception unit
`ifndef FPX_MAP_SVH
`define FPX_MAP_SVH

// Wishbone register byte addresses
`define FPX_ADR_CTRL      8'h00
`define FPX_ADR_STATUS    8'h04
`define FPX_ADR_MACHINE   8'h08
`define FPX_ADR_RES_LO    8'h0c
`define FPX_ADR_RES_HI    8'h10

// Control register fields
`define FPX_CTRL_ZE       0
`define FPX_CTRL_OE       1
`define FPX_CTRL_UE       2
`define FPX_CTRL_XE       3
`define FPX_CTRL_RM_LO    4
`define FPX_CTRL_RM_HI    5
`define FPX_CTRL_RESET    6'h00

// Status register fields
`define FPX_ST_FLAG_LO    0
`define FPX_ST_FLAG_HI    3
`define FPX_ST_FX         6
`define FPX_ST_FEX        7
`define FPX_ST_CLS_LO     8
`define FPX_ST_CLS_HI     12
`define FPX_FLAGS_RESET   4'h0
`define FPX_CLASS_RESET   5'h00

// Flag vector positions
`define FPX_F_ZX          0
`define FPX_F_OX          1
`define FPX_F_UX          2
`define FPX_F_XX          3

// Machine state register
`define FPX_MSR_FP        0
`define FPX_MSR_RESET     1'h0

// Exponent arithmetic, double precision
`define FPX_EXP_MAX       14'sh03ff
`define FPX_EXP_MIN       (-14'sh03fe)
`define FPX_EXP_ADJ       14'sh0600
`define FPX_EXP_BIAS      14'sh03ff
`define FPX_DN_CAP        7'h38

// Special encodings
`define FPX_EXP_ALL1      11'h7ff
`define FPX_EXP_LARGEST   11'h7fe
`define FPX_FRAC_ZERO     52'h0
`define FPX_FRAC_ALL1     52'hfffffffffffff

// Result class codes
`define FPX_CLS_PNORM     5'h04
`define FPX_CLS_NNORM     5'h08
`define FPX_CLS_PINF      5'h05
`define FPX_CLS_NINF      5'h09
`define FPX_CLS_PDEN      5'h14
`define FPX_CLS_NDEN      5'h18
`define FPX_CLS_PZERO     5'h02
`define FPX_CLS_NZERO     5'h12

`endif

//--- hdl/fpx_pkg.sv
// Types shared by the floating-point exception unit
package fpx_pkg;

	typedef enum logic [1:0] {
		FPX_RM_NEAREST = 2'b00,
		FPX_RM_ZERO    = 2'b01,
		FPX_RM_PINF    = 2'b10,
		FPX_RM_MINF    = 2'b11
	} fpx_rmode_t;

	typedef enum logic [1:0] {
		FPX_DLV_NONE   = 2'b00,
		FPX_DLV_RESULT = 2'b01,
		FPX_DLV_SUPP   = 2'b10
	} fpx_dlv_t;

endpackage

//--- hdl/fpx_round.sv
// Significand rounder: L, fraction, guard, round and sticky in, rounded significand out
`timescale 1ns/1ns
`default_nettype none

module fpx_round (
	input  wire logic [55:0]             sig,
	input  wire logic                    sign,
	input  wire fpx_pkg::fpx_rmode_t     mode,
	output logic      [52:0]             mant,
	output logic                         carry,
	output logic                         inexact
);
	logic        lsb;
	logic        grd;
	logic        rest;
	logic        inc;
	logic [53:0] sum;

	always_comb begin
		lsb  = sig[3];
		grd  = sig[2];
		rest = sig[1] | sig[0];
		case (mode)
			fpx_pkg::FPX_RM_NEAREST: inc = grd & (rest | lsb);
			fpx_pkg::FPX_RM_ZERO:    inc = 1'b0;
			fpx_pkg::FPX_RM_PINF:    inc = ~sign & (grd | rest);
			fpx_pkg::FPX_RM_MINF:    inc = sign & (grd | rest);
			default:                 inc = 1'b0;
		endcase
		sum     = {1'b0, sig[55:3]} + {53'h0, inc};
		carry   = sum[53];
		// A carry leaves only zeros below, so the dropped bit is always 0
		mant    = carry ? sum[53:1] : sum[52:0];
		inexact = grd | rest;
	end

endmodule

`default_nettype wire

//--- hdl/fpx_unit.sv
// Floating-point exception detection, result substitution and status flags with a Wishbone slave
// Function
// - Zero divide when divisor is zero and dividend finite nonzero.
// - Enabled zero divide suppresses the instruction and sets its flag.
// - Disabled zero divide sets flag, delivers infinity signed by XOR of operands.
// - Overflow when unbounded-range rounded magnitude exceeds largest finite number.
// - Enabled overflow sets flag, subtracts 1536 from exponent, class normal.
// - Disabled overflow sets overflow and inexact, delivers value, updates class.
// - Disabled overflow value chosen by rounding mode and sign.
// - Underflow: tiny if enabled, tiny plus accuracy loss if disabled.
// - Tiny judged before rounding: nonzero below smallest normalized number.
// - Tiny with underflow disabled is denormalized then rounded.
// - Accuracy loss means the delivered value is inexact.
// - Enabled underflow sets flag, adds 1536 to exponent, class normal.
// - Disabled underflow sets flag, delivers rounded denormal, zero or smallest normal, with its class.
// - Inexact when rounding changes value or overflow occurs while disabled.
// - Inexact sets flag, reports class, delivers rounded or overflowed value.
// - Float instructions run only with float available bit set, else interrupt.
// - Illegal opcode takes priority over float unavailable.
// - Exception flags stay set until software writes the status register.
// - Summary set on any flag rising; enabled summary on any enabled flag.
// - Rounding mode field: 00 nearest, 01 zero, 10 plus, 11 minus.
`timescale 1ns/1ns
`default_nettype none
`include "fpx_map.svh"

module fpx_unit (
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// Wishbone classic slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Instruction from dispatch and intermediate result from the datapath
	input  wire logic        OP_VALID,
	input  wire logic        OP_ILLEGAL,
	input  wire logic        OP_DIVIDE,
	input  wire logic        OPA_SIGN,
	input  wire logic        OPB_SIGN,
	input  wire logic        DIVISOR_ZERO,
	input  wire logic        DIVIDEND_FINITE_NONZERO,
	input  wire logic        IR_SIGN,
	input  wire logic [12:0] IR_EXP,
	input  wire logic [55:0] IR_SIG,
	input  wire logic        IR_NONZERO,
	// Completion
	output logic             RESULT_VALID,
	output logic             RESULT_WRITE,
	output logic             RESULT_SUPPRESS,
	output logic      [63:0] RESULT_DATA,
	output logic      [4:0]  RESULT_CLASS,
	output logic             FP_UNAVAIL_INT,
	output logic             ILLEGAL_OP_INT,
	output logic             ENABLED_SUMMARY
);

	////////////////////////////////////////////////////////////////////////////////
	// Software-visible state

	logic [5:0]  float_ctrl_r;
	logic        float_available_bit_r;
	logic [3:0]  flags_r;
	logic [3:0]  flags_nxt;
	logic        exception_summary_bit_r;
	logic        exception_summary_bit_nxt;
	logic        enabled_summary_bit_r;
	logic        enabled_summary_bit_nxt;
	logic [4:0]  result_class_field_r;
	logic [4:0]  result_class_field_nxt;
	logic [63:0] last_result_r;

	logic        div0_trap_enable;
	logic        overflow_enable;
	logic        underflow_enable;
	logic        inexact_enable;
	fpx_pkg::fpx_rmode_t rounding_mode_field;

	assign div0_trap_enable    = float_ctrl_r[`FPX_CTRL_ZE];
	assign overflow_enable     = float_ctrl_r[`FPX_CTRL_OE];
	assign underflow_enable    = float_ctrl_r[`FPX_CTRL_UE];
	assign inexact_enable      = float_ctrl_r[`FPX_CTRL_XE];
	assign rounding_mode_field = fpx_pkg::fpx_rmode_t'(float_ctrl_r[`FPX_CTRL_RM_HI:`FPX_CTRL_RM_LO]);

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack for one cycle

	logic        wb_req;
	logic        wb_wr;
	logic [31:0] wb_mask;
	logic [31:0] rd_data;
	logic [31:0] st_word;
	logic [31:0] st_written;
	logic [31:0] ctrl_written;

	assign wb_req  = WB_CYC_I & WB_STB_I;
	// Writes land on the edge where the master sees ack
	assign wb_wr   = wb_req & WB_WE_I & WB_ACK_O;
	assign wb_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

	assign st_word = {19'h0, result_class_field_r, enabled_summary_bit_r, exception_summary_bit_r, 2'h0, flags_r};
	assign st_written   = (st_word & ~wb_mask) | (WB_DAT_I & wb_mask);
	assign ctrl_written = ({26'h0, float_ctrl_r} & ~wb_mask) | (WB_DAT_I & wb_mask);

	always_comb begin
		case (WB_ADR_I)
			`FPX_ADR_CTRL:    rd_data = {26'h0, float_ctrl_r};
			`FPX_ADR_STATUS:  rd_data = st_word;
			`FPX_ADR_MACHINE: rd_data = {31'h0, float_available_bit_r};
			`FPX_ADR_RES_LO:  rd_data = last_result_r[31:0];
			`FPX_ADR_RES_HI:  rd_data = last_result_r[63:32];
			default:          rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
		end else begin
			WB_ACK_O <= wb_req & ~WB_ACK_O;
			if (wb_req & ~WB_ACK_O)
				WB_DAT_O <= rd_data;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			float_ctrl_r          <= `FPX_CTRL_RESET;
			float_available_bit_r <= `FPX_MSR_RESET;
		end else begin
			if (wb_wr && WB_ADR_I == `FPX_ADR_CTRL)
				float_ctrl_r <= ctrl_written[5:0];
			if (wb_wr && WB_ADR_I == `FPX_ADR_MACHINE && WB_SEL_I[0])
				float_available_bit_r <= WB_DAT_I[`FPX_MSR_FP];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Issue stage: capture the instruction and intermediate result

	logic        s_valid_r;
	logic        s_illegal_r;
	logic        s_divide_r;
	logic        s_xsign_r;
	logic        s_dzero_r;
	logic        s_dfnz_r;
	logic        s_sign_r;
	logic [12:0] s_exp_r;
	logic [55:0] s_sig_r;
	logic        s_nonzero_r;

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			s_valid_r <= 1'b0;
		end else begin
			s_valid_r <= OP_VALID;
		end
	end

	// Datapath fields need no reset; they are only read under s_valid_r
	always_ff @(posedge REF_CLK) begin
		if (OP_VALID) begin
			s_illegal_r <= OP_ILLEGAL;
			s_divide_r  <= OP_DIVIDE;
			s_xsign_r   <= OPA_SIGN ^ OPB_SIGN;
			s_dzero_r   <= DIVISOR_ZERO;
			s_dfnz_r    <= DIVIDEND_FINITE_NONZERO;
			s_sign_r    <= IR_SIGN;
			s_exp_r     <= IR_EXP;
			s_sig_r     <= IR_SIG;
			s_nonzero_r <= IR_NONZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Exception detection and result selection

	logic signed [13:0] e;
	logic signed [13:0] dn_diff;
	logic        [6:0]  dn_amt;
	logic        [55:0] dn_shf;
	logic               dn_lost;
	logic               tiny;
	logic               denorm;
	logic        [55:0] rnd_sig;
	logic signed [13:0] exp_pre;
	logic signed [13:0] exp_post;
	logic signed [13:0] bexp;
	logic        [52:0] mant;
	logic               carry;
	logic               rnd_inexact;
	logic               ovf;
	logic               unf;
	logic               zdiv;
	logic        [63:0] arith_val;
	logic        [63:0] ovf_val;
	logic        [63:0] dlv_val;
	logic        [4:0]  dlv_class;
	fpx_pkg::fpx_dlv_t  dlv;
	logic        [3:0]  hw_set;
	logic               unavail;

	assign e = {s_exp_r[12], s_exp_r};
	assign tiny = s_nonzero_r & (e < `FPX_EXP_MIN);
	assign denorm = tiny & ~underflow_enable;
	assign dn_diff = `FPX_EXP_MIN - e;
	assign dn_amt = (dn_diff > $signed({7'h0, `FPX_DN_CAP})) ? `FPX_DN_CAP : dn_diff[6:0];
	assign dn_shf = s_sig_r >> dn_amt;
	assign dn_lost = |(s_sig_r & ~({56{1'b1}} << dn_amt));
	// Bits shifted out fold into sticky so rounding and inexact stay correct
	assign rnd_sig = denorm ? {dn_shf[55:1], dn_shf[0] | dn_lost} : s_sig_r;

	always_comb begin
		if (tiny)
			exp_pre = underflow_enable ? e + `FPX_EXP_ADJ : `FPX_EXP_MIN;
		else
			exp_pre = e;
	end

	fpx_round u_round (
		.sig     (rnd_sig),
		.sign    (s_sign_r),
		.mode    (rounding_mode_field),
		.mant    (mant),
		.carry   (carry),
		.inexact (rnd_inexact)
	);

	assign exp_post = exp_pre + {13'h0, carry};
	// Exponent held in 14 bits, so no transient wrap before the compare
	assign ovf = s_nonzero_r & ~tiny & (exp_post > `FPX_EXP_MAX);
	assign unf = tiny & (underflow_enable | rnd_inexact);

	always_comb begin
		if (ovf)
			bexp = exp_post - `FPX_EXP_ADJ + `FPX_EXP_BIAS;
		else if (mant[52])
			bexp = exp_post + `FPX_EXP_BIAS;
		else
			bexp = 14'sh0000;
		if (s_nonzero_r)
			arith_val = {s_sign_r, bexp[10:0], mant[51:0]};
		else
			arith_val = {s_sign_r, 63'h0};
	end

	always_comb begin
		case (rounding_mode_field)
			fpx_pkg::FPX_RM_NEAREST:
				ovf_val = {s_sign_r, `FPX_EXP_ALL1, `FPX_FRAC_ZERO};
			fpx_pkg::FPX_RM_ZERO:
				ovf_val = {s_sign_r, `FPX_EXP_LARGEST, `FPX_FRAC_ALL1};
			fpx_pkg::FPX_RM_PINF:
				ovf_val = s_sign_r ? {1'b1, `FPX_EXP_LARGEST, `FPX_FRAC_ALL1} : {1'b0, `FPX_EXP_ALL1, `FPX_FRAC_ZERO};
			fpx_pkg::FPX_RM_MINF:
				ovf_val = s_sign_r ? {1'b1, `FPX_EXP_ALL1, `FPX_FRAC_ZERO} : {1'b0, `FPX_EXP_LARGEST, `FPX_FRAC_ALL1};
			default:
				ovf_val = {s_sign_r, `FPX_EXP_ALL1, `FPX_FRAC_ZERO};
		endcase
	end

	assign zdiv    = s_divide_r & s_dzero_r & s_dfnz_r;
	assign unavail = ~s_illegal_r & ~float_available_bit_r;

	always_comb begin
		dlv     = fpx_pkg::FPX_DLV_NONE;
		hw_set  = 4'h0;
		dlv_val = arith_val;
		if (s_valid_r) begin
			if (s_illegal_r || unavail) begin
				dlv = fpx_pkg::FPX_DLV_SUPP;
			end else if (zdiv) begin
				hw_set[`FPX_F_ZX] = 1'b1;
				if (div0_trap_enable) begin
					dlv = fpx_pkg::FPX_DLV_SUPP;
				end else begin
					dlv     = fpx_pkg::FPX_DLV_RESULT;
					dlv_val = {s_xsign_r, `FPX_EXP_ALL1, `FPX_FRAC_ZERO};
				end
			end else begin
				dlv = fpx_pkg::FPX_DLV_RESULT;
				hw_set[`FPX_F_OX] = ovf;
				hw_set[`FPX_F_UX] = unf;
				hw_set[`FPX_F_XX] = rnd_inexact | (ovf & ~overflow_enable);
				if (ovf && !overflow_enable)
					dlv_val = ovf_val;
			end
		end
	end

	fpx_class u_class (
		.val (dlv_val),
		.cls (dlv_class)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sticky flags and summaries; hardware set wins over a software clear

	always_comb begin
		if (wb_wr && WB_ADR_I == `FPX_ADR_STATUS) begin
			flags_nxt                 = st_written[`FPX_ST_FLAG_HI:`FPX_ST_FLAG_LO];
			exception_summary_bit_nxt = st_written[`FPX_ST_FX];
			result_class_field_nxt    = st_written[`FPX_ST_CLS_HI:`FPX_ST_CLS_LO];
		end else begin
			flags_nxt                 = flags_r;
			exception_summary_bit_nxt = exception_summary_bit_r;
			result_class_field_nxt    = result_class_field_r;
		end
		flags_nxt = flags_nxt | hw_set;
		exception_summary_bit_nxt = exception_summary_bit_nxt | (|(hw_set & ~flags_r));
		if (dlv == fpx_pkg::FPX_DLV_RESULT)
			result_class_field_nxt = dlv_class;
		enabled_summary_bit_nxt = |(flags_nxt & {inexact_enable, underflow_enable,
			overflow_enable, div0_trap_enable});
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			flags_r                 <= `FPX_FLAGS_RESET;
			exception_summary_bit_r <= 1'b0;
			enabled_summary_bit_r   <= 1'b0;
			result_class_field_r    <= `FPX_CLASS_RESET;
		end else begin
			flags_r                 <= flags_nxt;
			exception_summary_bit_r <= exception_summary_bit_nxt;
			enabled_summary_bit_r   <= enabled_summary_bit_nxt;
			result_class_field_r    <= result_class_field_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Completion outputs, all registered on the same edge as the status

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			RESULT_VALID    <= 1'b0;
			RESULT_WRITE    <= 1'b0;
			RESULT_SUPPRESS <= 1'b0;
			RESULT_DATA     <= 64'h0;
			last_result_r   <= 64'h0;
			FP_UNAVAIL_INT  <= 1'b0;
			ILLEGAL_OP_INT  <= 1'b0;
		end else begin
			RESULT_VALID    <= s_valid_r;
			RESULT_WRITE    <= (dlv == fpx_pkg::FPX_DLV_RESULT);
			RESULT_SUPPRESS <= (dlv == fpx_pkg::FPX_DLV_SUPP);
			FP_UNAVAIL_INT  <= s_valid_r & unavail;
			ILLEGAL_OP_INT  <= s_valid_r & s_illegal_r;
			if (dlv == fpx_pkg::FPX_DLV_RESULT) begin
				RESULT_DATA   <= dlv_val;
				last_result_r <= dlv_val;
			end
		end
	end

	assign RESULT_CLASS    = result_class_field_r;
	assign ENABLED_SUMMARY = enabled_summary_bit_r;

endmodule

`default_nettype wire

//--- test/fpx_dp_model.sv
// Dispatch and datapath stand-in that issues one instruction per request
`timescale 1ns/1ns
`default_nettype none

module fpx_dp_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        req,
	input  wire logic [76:0] fld,
	output logic             op_valid,
	output logic      [76:0] op_fld
);
	// Fields scramble between issues so the unit cannot lean on stale operands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_valid <= 1'b0;
			op_fld <= 77'h0;
		end else begin
			op_valid <= req;
			op_fld <= req ? fld : ~op_fld;
		end
	end
endmodule
`default_nettype wire

//--- test/fpx_unit_asserts.sv
// Concurrent checks on the completion behaviour of the exception unit
`timescale 1ns/1ns
`default_nettype none
`include "fpx_map.svh"

module fpx_unit_asserts (
	input wire logic        REF_CLK,
	input wire logic        RESET,
	input wire logic        OP_VALID,
	input wire logic        OP_ILLEGAL,
	input wire logic        OP_DIVIDE,
	input wire logic        OPA_SIGN,
	input wire logic        OPB_SIGN,
	input wire logic        DIVISOR_ZERO,
	input wire logic        DIVIDEND_FINITE_NONZERO,
	input wire logic        RESULT_VALID,
	input wire logic        RESULT_WRITE,
	input wire logic        RESULT_SUPPRESS,
	input wire logic [63:0] RESULT_DATA,
	input wire logic [4:0]  RESULT_CLASS,
	input wire logic        FP_UNAVAIL_INT,
	input wire logic        ILLEGAL_OP_INT
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	sequence zd_s;
		OP_VALID && OP_DIVIDE && DIVISOR_ZERO && DIVIDEND_FINITE_NONZERO && !OP_ILLEGAL;
	endsequence
	sequence inf_s;
		RESULT_WRITE && RESULT_DATA[62:52] == 11'h7ff && RESULT_DATA[51:0] == 52'h0;
	endsequence
	done_latency_a: assert property (OP_VALID |-> ##2 RESULT_VALID)
		else $error("completion not two cycles after issue");
	one_outcome_a: assert property (RESULT_VALID |-> RESULT_WRITE != RESULT_SUPPRESS)
		else $error("completion without exactly one of write or suppress");
	pulse_owned_a: assert property ((RESULT_WRITE || FP_UNAVAIL_INT || ILLEGAL_OP_INT) |-> RESULT_VALID)
		else $error("result pulse outside completion");
	illegal_first_a: assert property (OP_VALID && OP_ILLEGAL |-> ##2 ILLEGAL_OP_INT && !FP_UNAVAIL_INT)
		else $error("illegal opcode lost priority");
	unavail_supp_a: assert property (FP_UNAVAIL_INT |-> RESULT_SUPPRESS && !RESULT_WRITE)
		else $error("unavailable unit did not suppress");
	div0_inf_a: assert property (zd_s ##2 RESULT_WRITE |-> RESULT_DATA[62:0] == {11'h7ff, 52'h0}
		&& RESULT_DATA[63] == $past(OPA_SIGN ^ OPB_SIGN, 2)) else $error("zero divide result not signed infinity");
	inf_class_a: assert property (inf_s |-> RESULT_CLASS == (RESULT_DATA[63] ? `FPX_CLS_NINF : `FPX_CLS_PINF))
		else $error("infinity delivered with wrong class");
	den_class_a: assert property (RESULT_WRITE && RESULT_DATA[62:52] == 11'h0 && RESULT_DATA[51:0] != 52'h0
		|-> RESULT_CLASS == (RESULT_DATA[63] ? `FPX_CLS_NDEN : `FPX_CLS_PDEN)) else $error("denormal class wrong");
	data_hold_a: assert property (!$stable(RESULT_DATA) |-> RESULT_WRITE)
		else $error("result data moved without a write");
endmodule

bind fpx_unit fpx_unit_asserts chk (
	.REF_CLK(REF_CLK), .RESET(RESET), .OP_VALID(OP_VALID), .OP_ILLEGAL(OP_ILLEGAL), .OP_DIVIDE(OP_DIVIDE),
	.OPA_SIGN(OPA_SIGN), .OPB_SIGN(OPB_SIGN), .DIVISOR_ZERO(DIVISOR_ZERO),
	.DIVIDEND_FINITE_NONZERO(DIVIDEND_FINITE_NONZERO), .RESULT_VALID(RESULT_VALID), .RESULT_WRITE(RESULT_WRITE),
	.RESULT_SUPPRESS(RESULT_SUPPRESS), .RESULT_DATA(RESULT_DATA), .RESULT_CLASS(RESULT_CLASS),
	.FP_UNAVAIL_INT(FP_UNAVAIL_INT), .ILLEGAL_OP_INT(ILLEGAL_OP_INT)
);
`default_nettype wire

//--- test/fpx_unit_tb.sv
// Self-checking bench for the exception unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, ex) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

module fpx_unit_tb;
	localparam logic [55:0] ONE = 56'h80000000000000;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        we  = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic        req = 1'b0;
	logic [76:0] fld = 77'h0;
	logic [31:0] rdat, mr;
	logic        ack, rv, rw, rs, fu, il, es, opv, s, t;
	logic [63:0] rdata, e;
	logic [4:0]  rcls, cls;
	logic [76:0] opf;
	logic [72:0] mq;
	logic [72:0] opq[$];
	logic [31:0] rdq[$];
	int          n_mismatch = 0;
	int          total_checks = 0;

	initial forever #25 clk = ~clk;

	fpx_dp_model model (.clk(clk), .rst(rst), .req(req), .fld(fld), .op_valid(opv), .op_fld(opf));
	fpx_unit dut (
		.REF_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .OP_VALID(opv),
		.OP_ILLEGAL(opf[76]), .OP_DIVIDE(opf[75]), .OPA_SIGN(opf[74]), .OPB_SIGN(opf[73]),
		.DIVISOR_ZERO(opf[72]), .DIVIDEND_FINITE_NONZERO(opf[71]), .IR_SIGN(opf[70]), .IR_NONZERO(opf[69]),
		.IR_EXP(opf[68:56]), .IR_SIG(opf[55:0]), .RESULT_VALID(rv), .RESULT_WRITE(rw), .RESULT_SUPPRESS(rs),
		.RESULT_DATA(rdata), .RESULT_CLASS(rcls), .FP_UNAVAIL_INT(fu), .ILLEGAL_OP_INT(il), .ENABLED_SUMMARY(es)
	);

	function automatic logic [76:0] mk(logic [7:0] c, logic [12:0] x, logic [55:0] g);
		return {c, x, g};
	endfunction
	function automatic logic [72:0] ex(logic [3:0] k, logic [4:0] c, logic [63:0] d);
		return {k, c, d};
	endfunction
	function automatic logic [63:0] inf(logic g);
		return {g, 11'h7ff, 52'h0};
	endfunction
	function automatic logic [63:0] mx(logic g);
		return {g, 11'h7fe, 52'hfffffffffffff};
	endfunction

	// Waits as long as the slave needs; only the watchdog ends a hang
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] x);
		rdq.push_back(x);
		wb(1'b0, a, 32'h0);
	endtask
	// No gap between calls, so consecutive calls issue back to back
	task automatic op(logic [76:0] f, logic [72:0] x);
		@(posedge clk);
		req <= 1'b1;
		fld <= f;
		opq.push_back(x);
	endtask
	task automatic idle;
		@(posedge clk);
		req <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	always @(posedge clk) begin
		if (rv === 1'b1 && opq.size() == 0) `CHK("completion queued", 1'b0, 1'b1)
		else if (rv === 1'b1) begin
			mq = opq.pop_front();
			`CHK("write", rw, mq[72])
			`CHK("suppress", rs, mq[71])
			`CHK("unavail", fu, mq[70])
			`CHK("illegal", il, mq[69])
			if (mq[72]) `CHK("class", rcls, mq[68:64])
			if (mq[72]) `CHK("data", rdata, mq[63:0])
		end
		if (ack === 1'b1 && we === 1'b0) begin
			mr = rdq.pop_front();
			`CHK("rdata", rdat, mr)
		end
	end

	// Whole sequence needs about 260 cycles
	initial begin
		#(30000 * 50);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h93a3));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
		wb(1'b1, 8'h0c, 32'hffffffff);
		rd(8'h0c, 32'h0);
		rd(8'h40, 32'h0);
		op(mk(8'h01, 13'h0, ONE), ex(4'h6, 5'h0, 64'h0));
		op(mk(8'h81, 13'h0, ONE), ex(4'h5, 5'h0, 64'h0));
		idle();
		rd(8'h04, 32'h0);
		wb(1'b1, 8'h08, 32'h1);
		wb(1'b1, 8'h00, 32'h1);
		op(mk(8'h4d, 13'h0, ONE), ex(4'h4, 5'h0, 64'h0));
		idle();
		`CHK("enabled summary", es, 1'b1)
		rd(8'h04, 32'hc1);
		wb(1'b1, 8'h00, 32'h0);
		for (int i = 0; i < 4; i++) begin
			s = 1'($urandom());
			t = 1'($urandom());
			cls = (s ^ t) ? 5'h09 : 5'h05;
			op(mk({2'b01, s, t, 4'hd}, 13'h0, ONE), ex(4'h8, cls, inf(s ^ t)));
		end
		idle();
		rd(8'h04, {19'h0, cls, 8'h41});
		wb(1'b1, 8'h04, 32'h0);
		rd(8'h04, 32'h0);
		for (int m = 0; m < 8; m++) begin
			s = m[0];
			case (m[2:1])
				0: e = inf(s);
				1: e = mx(s);
				2: e = s ? mx(1'b1) : inf(1'b0);
				default: e = s ? inf(1'b1) : mx(1'b0);
			endcase
			cls = (e[62:52] == 11'h7ff) ? (s ? 5'h09 : 5'h05) : (s ? 5'h08 : 5'h04);
			wb(1'b1, 8'h00, {26'h0, m[2:1], 4'h0});
			op(mk({6'h0, s, 1'b1}, 13'h0400, ONE), ex(4'h8, cls, e));
			idle();
		end
		rd(8'h04, {19'h0, cls, 8'h4a});
		for (int k = 0; k < 2; k++) begin
			s = 1'($urandom());
			cls = s ? 5'h08 : 5'h04;
			wb(1'b1, 8'h04, 32'h0);
			wb(1'b1, 8'h00, k ? 32'h4 : 32'h2);
			op(mk({6'h0, s, 1'b1}, k ? 13'h1c01 : 13'h0400, ONE),
				ex(4'h8, cls, {s, k ? 11'h600 : 11'h1ff, 52'h0}));
			idle();
			`CHK("enabled summary", es, 1'b1)
			rd(8'h04, {19'h0, cls, k ? 8'hc4 : 8'hc2});
		end
		wb(1'b1, 8'h04, 32'h0);
		wb(1'b1, 8'h00, 32'h10);
		op(mk(8'h02, 13'h1c01, ONE), ex(4'h8, 5'h12, {1'b1, 63'h0}));
		op(mk(8'h01, 13'h1c01, ONE), ex(4'h8, 5'h14, 64'h0008000000000000));
		idle();
		rd(8'h04, {19'h0, 5'h14, 8'h00});
		op(mk(8'h03, 13'h1c01, ONE | 56'h1), ex(4'h8, 5'h18, 64'h8008000000000000));
		idle();
		rd(8'h04, {19'h0, 5'h18, 8'h4c});
		for (int m = 1; m < 4; m++) begin
			e = (m == 3) ? 64'hbff0000000000001 : 64'hbff0000000000000;
			wb(1'b1, 8'h00, {26'h0, m[1:0], 4'h0});
			op(mk(8'h03, 13'h0, ONE | 56'h1), ex(4'h8, 5'h08, e));
			idle();
		end
		rd(8'h04, {19'h0, 5'h08, 8'h4c});
		repeat (5) @(posedge clk);
		`CHK("pending", opq.size(), 0)
		wrap_up();
	end
endmodule
`default_nettype wire
